// ---- hw/sosm_pkg.sv ----
// Package for the sensor output state machine: constants, types and states
package sosm_pkg;

    // Clock and timing
    localparam int CLK_HZ = 20000000;
    localparam int HOLD_DIM_MS = 1000;
    localparam int HOLD_DIM_CYCLES = (CLK_HZ / 1000) * HOLD_DIM_MS;
    localparam int ZOOM_RATE_HZ = 60;
    localparam int ZOOM_TICK_CYCLES = CLK_HZ / ZOOM_RATE_HZ;

    // Default dwell length in sample ticks and default duty step
    localparam int DWELL_TICKS_DEF = 600;
    localparam int DUTY_W = 8;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
    localparam logic [DUTY_W-1:0] DUTY_STEP_DEF = 8'h04;
    localparam logic [DUTY_W-1:0] DUTY_PWM_DEF = 8'h40;

    // Reset values
    localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;

    // Sensor channel numbers
    localparam logic [1:0] CH_TOUCH = 2'h0;
    localparam logic [1:0] CH_PIR = 2'h1;
    localparam logic [1:0] CH_INDUCTIVE = 2'h2;

    // Output states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PWM,
        ST_ON
    } sosm_state_type;

    // Sensor event bundle
    typedef struct packed {
        logic movement;
        logic prox;
        logic touch;
        logic metal_enter;
        logic metal_exit;
        logic coil_touch;
    } sosm_events_type;

    // Output driver and sensing mode configuration, held in nonvolatile storage
    typedef struct packed {
        logic open_drain;
        logic active_low;
        logic pwm_enable;
        logic metal_mode;
        logic coil_reject_en;
    } sosm_cfg_type;

endpackage : sosm_pkg

// ---- hw/sosm_top.sv ----
// Output state machine of a movement, touch and metal sensing device
`timescale 1ns/1ps

module sosm_top #(
    parameter int DWELL_TICKS = sosm_pkg::DWELL_TICKS_DEF,
    parameter int HOLD_CYCLES = sosm_pkg::HOLD_DIM_CYCLES,
    parameter int ZOOM_CYCLES = sosm_pkg::ZOOM_TICK_CYCLES
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic SAMPLE_TICK_I,
    input wire sosm_pkg::sosm_events_type EVENTS_I,
    input wire logic TOUCH_LEVEL_I,
    input wire sosm_pkg::sosm_cfg_type CFG_I,
    input wire logic [sosm_pkg::DUTY_W-1:0] DUTY_STEP_I,
    input wire logic [sosm_pkg::DUTY_W-1:0] DUTY_PWM_I,
    output logic OUT_O,
    output logic OUT_OE_O,
    output logic FAST_SAMPLE_O,
    output logic ZOOM_TICK_O,
    output logic [1:0] STATE_O,
    output logic [sosm_pkg::DUTY_W-1:0] DUTY_O
);
    import sosm_pkg::*;

    localparam int DW_W = $clog2(DWELL_TICKS + 1);
    localparam int HD_W = $clog2(HOLD_CYCLES + 1);
    localparam int ZM_W = $clog2(ZOOM_CYCLES + 1);

    sosm_state_type state_ff;
    sosm_state_type nxt_state;
    logic [DW_W-1:0] dwell_ff;
    logic [HD_W-1:0] hold_ff;
    logic [ZM_W-1:0] zoom_ff;
    logic [DUTY_W-1:0] duty_ff;
    logic [DUTY_W-1:0] pwm_cnt_ff;
    logic dim_down_ff;
    logic dimming_ff;
    logic fast_ff;
    logic touch_ev;
    logic metal_in;
    logic drive_level;

    // Touch on the coil suppresses the metal response when rejection is enabled
    assign metal_in = EVENTS_I.coil_touch & CFG_I.coil_reject_en;
    assign touch_ev = EVENTS_I.touch & ~CFG_I.metal_mode;

    // Next output state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (CFG_I.metal_mode && EVENTS_I.metal_exit && !metal_in) begin
                    nxt_state = ST_ON;
                end else if (touch_ev) begin
                    nxt_state = ST_ON;
                end else if (EVENTS_I.movement) begin
                    nxt_state = ST_PWM;
                end
            end
            ST_PWM: begin
                if (CFG_I.metal_mode && EVENTS_I.metal_exit && !metal_in) begin
                    nxt_state = ST_ON;
                end else if (touch_ev) begin
                    nxt_state = ST_ON;
                end else if (!EVENTS_I.movement && SAMPLE_TICK_I && dwell_ff == DW_W'(1)) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ON: begin
                if (CFG_I.metal_mode && EVENTS_I.metal_enter && !metal_in) begin
                    nxt_state = ST_IDLE;
                end else if (touch_ev) begin
                    nxt_state = ST_IDLE;
                end
                // Movement has no effect here
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Dwell timer, reloaded on movement outside ST_ON, counts sample ticks
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dwell_ff <= '0;
        end else if (EVENTS_I.movement && state_ff != ST_ON) begin
            dwell_ff <= DW_W'(DWELL_TICKS);
        end else if (state_ff == ST_PWM && SAMPLE_TICK_I && dwell_ff != '0) begin
            dwell_ff <= dwell_ff - DW_W'(1);
        end
    end

    // Held-touch timer for dimming
    always_ff @(posedge CLK_I) begin
        if (SRST_I || !TOUCH_LEVEL_I || state_ff != ST_ON) begin
            hold_ff <= '0;
            dimming_ff <= 1'b0;
        end else if (hold_ff < HD_W'(HOLD_CYCLES)) begin
            hold_ff <= hold_ff + HD_W'(1);
        end else begin
            dimming_ff <= 1'b1;
        end
    end

    // Duty ramp on sample ticks while dimming
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            duty_ff <= DUTY_RST;
            dim_down_ff <= 1'b1;
        end else if (state_ff != ST_ON || nxt_state == ST_IDLE) begin
            duty_ff <= DUTY_FULL;
            dim_down_ff <= 1'b1;
        end else if (dimming_ff && TOUCH_LEVEL_I && SAMPLE_TICK_I) begin
            if (dim_down_ff) begin
                if (duty_ff <= DUTY_STEP_I) begin
                    duty_ff <= '0;
                    dim_down_ff <= 1'b0;
                end else begin
                    duty_ff <= duty_ff - DUTY_STEP_I;
                end
            end else begin
                if (duty_ff >= DUTY_FULL - DUTY_STEP_I) begin
                    duty_ff <= DUTY_FULL;
                end else begin
                    duty_ff <= duty_ff + DUTY_STEP_I;
                end
            end
        end
    end

    // Fast sampling mode on proximity outside metal mode, left on a state change while the touch level is low
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            fast_ff <= 1'b0;
        end else if (EVENTS_I.prox && !CFG_I.metal_mode) begin
            fast_ff <= 1'b1;
        end else if (!TOUCH_LEVEL_I && nxt_state != state_ff) begin
            fast_ff <= 1'b0;
        end
    end

    // Fast sampling tick generator at 60 Hz
    always_ff @(posedge CLK_I) begin
        if (SRST_I || !fast_ff) begin
            zoom_ff <= '0;
            ZOOM_TICK_O <= 1'b0;
        end else if (zoom_ff >= ZM_W'(ZOOM_CYCLES - 1)) begin
            zoom_ff <= '0;
            ZOOM_TICK_O <= 1'b1;
        end else begin
            zoom_ff <= zoom_ff + ZM_W'(1);
            ZOOM_TICK_O <= 1'b0;
        end
    end

    // PWM carrier counter
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pwm_cnt_ff <= '0;
        end else begin
            pwm_cnt_ff <= pwm_cnt_ff + DUTY_W'(1);
        end
    end

    // Output level before polarity and driver style
    always_comb begin
        drive_level = 1'b0;
        unique case (state_ff)
            ST_IDLE: drive_level = 1'b0;
            ST_PWM: drive_level = CFG_I.pwm_enable ? (pwm_cnt_ff < DUTY_PWM_I) : 1'b1;
            ST_ON: drive_level = (duty_ff == DUTY_FULL) || (pwm_cnt_ff < duty_ff);
        endcase
    end

    // Output pin register with polarity and open-drain handling
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            OUT_O <= 1'b0;
            OUT_OE_O <= 1'b0;
            FAST_SAMPLE_O <= 1'b0;
            STATE_O <= 2'h0;
            DUTY_O <= DUTY_RST;
        end else begin
            OUT_O <= drive_level ^ CFG_I.active_low;
            OUT_OE_O <= CFG_I.open_drain ? ((drive_level ^ CFG_I.active_low) == 1'b0) : 1'b1;
            FAST_SAMPLE_O <= fast_ff;
            STATE_O <= state_ff;
            DUTY_O <= (state_ff == ST_ON) ? duty_ff : ((state_ff == ST_PWM) ? DUTY_PWM_I : DUTY_RST);
        end
    end

endmodule : sosm_top

// ---- bench/sosm_monitor.sv ----
// Checker bound to the output state machine ports
`timescale 1ns/1ps
module sosm_monitor (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic SAMPLE_TICK_I,
    input wire sosm_pkg::sosm_events_type EVENTS_I,
    input wire sosm_pkg::sosm_cfg_type CFG_I,
    input wire logic OUT_O,
    input wire logic OUT_OE_O,
    input wire logic FAST_SAMPLE_O,
    input wire logic ZOOM_TICK_O,
    input wire logic [1:0] STATE_O
);
    import sosm_pkg::*;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    // Qualified touch, movement and metal events
    wire tch = EVENTS_I.touch && !CFG_I.metal_mode;
    wire mv = EVENTS_I.movement && !CFG_I.metal_mode;
    wire mt = CFG_I.metal_mode && !(EVENTS_I.coil_touch && CFG_I.coil_reject_en);
    a_move_to_pwm:
        assert property (mv && !tch ##1 STATE_O == 2'h0 |=> STATE_O == 2'h1) else $error("no pwm on movement");
    a_on_ignore_move:
        assert property (mv && !tch ##1 STATE_O == 2'h2 |=> STATE_O == 2'h2) else $error("movement left on");
    a_touch_turn_on:
        assert property (tch ##1 STATE_O != 2'h2 |=> STATE_O == 2'h2) else $error("touch did not turn on");
    a_touch_turn_off:
        assert property (tch ##1 STATE_O == 2'h2 |=> STATE_O == 2'h0) else $error("touch did not turn off");
    a_metal_enter_off:
        assert property (EVENTS_I.metal_enter && mt |=> ##1 STATE_O == 2'h0) else $error("metal did not turn off");
    a_metal_exit_on:
        assert property (EVENTS_I.metal_exit && !EVENTS_I.metal_enter && mt |=> ##1 STATE_O == 2'h2)
            else $error("metal exit did not turn on");
    a_coil_reject_touch:
        assert property ((EVENTS_I.metal_enter || EVENTS_I.metal_exit) && EVENTS_I.coil_touch && CFG_I.coil_reject_en
            && CFG_I.metal_mode && !SAMPLE_TICK_I |=> ##1 $stable(STATE_O)) else $error("coil touch not rejected");
    a_prox_fast:
        assert property (EVENTS_I == 6'h10 && !CFG_I.metal_mode && !SAMPLE_TICK_I |=> ##1 FAST_SAMPLE_O)
            else $error("prox did not select fast");
    a_zoom_pulse:
        assert property (ZOOM_TICK_O |=> !ZOOM_TICK_O [*8]) else $error("zoom tick too close");
    a_od_low_only:
        assert property (CFG_I.open_drain && OUT_OE_O |-> !OUT_O) else $error("open drain drove high");
endmodule : sosm_monitor
bind sosm_top sosm_monitor u_mon (.CLK_I(CLK_I), .SRST_I(SRST_I), .SAMPLE_TICK_I(SAMPLE_TICK_I),
    .EVENTS_I(EVENTS_I), .CFG_I(CFG_I), .OUT_O(OUT_O), .OUT_OE_O(OUT_OE_O),
    .FAST_SAMPLE_O(FAST_SAMPLE_O), .ZOOM_TICK_O(ZOOM_TICK_O), .STATE_O(STATE_O));

// ---- bench/sosm_lamp_model.sv ----
// Load on the logic output: resolves the pin and reports the lamp
`timescale 1ns/1ps
module sosm_lamp_model (
    input wire logic clk_i,
    input wire logic out_i,
    input wire logic oe_i,
    input wire sosm_pkg::sosm_cfg_type cfg_i,
    output logic lamp_on_o
);
    import sosm_pkg::*;
    logic pin_last_ff = 1'b0;
    logic pin;
    // Pull-up on open drain, inverse of last level when floating otherwise
    assign pin = oe_i ? out_i : (cfg_i.open_drain ? 1'b1 : ~pin_last_ff);
    always_ff @(posedge clk_i) pin_last_ff <= pin;
    // Polarity picks the lit level
    assign lamp_on_o = pin ^ cfg_i.active_low;
endmodule : sosm_lamp_model

// ---- bench/sosm_top_tb.sv ----
// Self-checking bench of the output state machine
`timescale 1ns/1ps
module sosm_top_tb;
    import sosm_pkg::*;
    localparam int DW = 5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic lvl = 1'b0;
    sosm_events_type ev = '0;
    sosm_cfg_type cfg = '0;
    logic out, oe, fast, ztk, lamp;
    logic [1:0] st;
    logic [7:0] duty;
    int n_fail = 0;
    int n_tests = 0;
    int ms = 0, ms_d = 0, dw = 0, k = 0;
    logic [31:0] seed = 32'h3284d152;
    always #25 clk = ~clk;
    sosm_top #(.DWELL_TICKS(DW), .HOLD_CYCLES(20), .ZOOM_CYCLES(10)) DUT (.CLK_I(clk), .SRST_I(rst),
        .SAMPLE_TICK_I(tick), .EVENTS_I(ev), .TOUCH_LEVEL_I(lvl), .CFG_I(cfg), .DUTY_STEP_I(8'h33),
        .DUTY_PWM_I(DUTY_PWM_DEF), .OUT_O(out), .OUT_OE_O(oe), .FAST_SAMPLE_O(fast), .ZOOM_TICK_O(ztk),
        .STATE_O(st), .DUTY_O(duty));
    sosm_lamp_model u_lamp (.clk_i(clk), .out_i(out), .oe_i(oe), .cfg_i(cfg), .lamp_on_o(lamp));
    // Reference model of the output state
    always @(posedge clk) begin
        ms_d <= ms;
        if (rst) begin
            ms <= 0;
            dw <= 0;
        end else if (cfg.metal_mode) begin
            if (!(ev.coil_touch && cfg.coil_reject_en) && ev.metal_enter) ms <= 0;
            else if (!(ev.coil_touch && cfg.coil_reject_en) && ev.metal_exit) ms <= 2;
        end else if (ev.touch) ms <= (ms == 2) ? 0 : 2;
        else if (ev.movement && ms != 2) begin
            ms <= 1;
            dw <= DW;
        end else if (tick && ms == 1) begin
            dw <= dw - 1;
            if (dw == 1) ms <= 0;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic do_reset(input sosm_cfg_type c);
        @(negedge clk);
        rst = 1'b1;
        cfg = c;
        ev = '0;
        tick = 1'b0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
    endtask : do_reset
    task automatic rand_run(input int n);
        repeat (n) begin
            @(negedge clk);
            check(8'(st), 8'(ms_d));
            check(duty, (ms_d == 2) ? DUTY_FULL : ((ms_d == 1) ? DUTY_PWM_DEF : 8'h00));
            if (ms_d != 1 || !cfg.pwm_enable) check(8'(lamp), 8'(ms_d != 0));
            seed = xs(seed);
            ev.movement = !cfg.metal_mode && seed[2:0] == 3'h0;
            ev.touch = seed[6:3] == 4'h0;
            ev.prox = seed[9:7] == 3'h0;
            ev.metal_enter = cfg.metal_mode && seed[11:10] == 2'h0;
            ev.metal_exit = cfg.metal_mode && seed[11:10] == 2'h1;
            ev.coil_touch = seed[12];
            tick = seed[14:13] == 2'h0;
        end
    endtask : rand_run
    task automatic tick_once;
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        @(negedge clk);
    endtask : tick_once
    initial begin
        #(4000 * 50);
        n_fail++;
        end_sim;
    end
    initial begin
        for (k = 0; k < 4; k++) begin
            do_reset(sosm_cfg_type'({k[1:0], ~k[1], 2'b00}));
            check(8'(lamp), 8'h0);
            check(8'({st, fast}), 8'h0);
            rand_run(300);
        end
        do_reset(5'b00100);
        ev.touch = 1'b1;
        lvl = 1'b1;
        @(negedge clk);
        ev = '0;
        tick_once;
        check(duty, DUTY_FULL);
        repeat (20) @(negedge clk);
        repeat (5) tick_once;
        check(duty, 8'h00);
        tick_once;
        check(duty, 8'h33);
        lvl = 1'b0;
        tick_once;
        check(duty, 8'h33);
        do_reset(5'b00100);
        ev.prox = 1'b1;
        @(negedge clk);
        ev = '0;
        @(negedge clk);
        check(8'({st, fast}), 8'h1);
        k = 0;
        repeat (30) begin
            @(negedge clk);
            k += int'(ztk);
        end
        check(8'(k), 8'h3);
        do_reset(5'b00111);
        rand_run(300);
        do_reset(5'b00110);
        rand_run(200);
        end_sim;
    end
endmodule : sosm_top_tb
